// File: inc/serial_pkg.sv
// Package: register map, field positions, reset values and timing of the serial port
`default_nettype none
package serial_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [3:0] IDX_CTRL = 4'h0;
	localparam logic [3:0] IDX_TXDATA = 4'h1;
	localparam logic [3:0] IDX_RXDATA = 4'h2;
	localparam logic [3:0] IDX_LINESTAT = 4'h3;
	localparam logic [3:0] IDX_FORMAT = 4'h4;
	localparam logic [3:0] IDX_MODEM = 4'h5;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h6;
	localparam logic [3:0] IDX_IRQ_CLR = 4'h7;
	localparam logic [3:0] IDX_IRQ_EN = 4'h8;
	localparam logic [3:0] IDX_RXERR = 4'hA;
	// Transfer control fields
	localparam int CTRL_OUT = 0;
	localparam int CTRL_IN = 1;
	// Modem line control fields
	localparam int MLC_HOLD_DTR = 0;
	localparam int MLC_HOLD_RTS = 1;
	localparam int MLC_SRTS = 2;
	localparam int MLC_DRS = 3;
	// Receive error fields
	localparam int ERR_OVR = 1;
	localparam int ERR_PAR = 2;
	localparam int ERR_FRM = 3;
	localparam int ERR_BRK = 4;
	// Character format fields and parity senses
	localparam int FMT_PEN = 3;
	localparam int FMT_SENSE = 4;
	localparam logic [1:0] PAR_ODD = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ONE = 2'h2;
	// Line status fields
	localparam int LS_TX_BUSY = 0;
	localparam int LS_TX_PEND = 1;
	localparam int LS_RX_FULL = 2;
	localparam int LS_DSR = 3;
	localparam int LS_CTS = 4;
	localparam int LS_DCD = 5;
	// Interrupt event fields
	localparam int EV_TX_DONE = 0;
	localparam int EV_RX_CHAR = 1;
	localparam int EV_RX_ERR = 2;
	// Reset values
	localparam logic [7:0] MODEM_RST = 8'h00;
	localparam logic [7:0] FORMAT_RST = 8'h00;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// Timing: one bit at 9600 baud on a 100 MHz clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 104167;
	localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: rtl/serial_port.sv
// Serial port: modem handshake, character shifter, receive error status, Wishbone registers
`default_nettype none

// Notes on behaviour
// - Transmit transfer start drives DTR and RTS active unless held.
// - A character starts going out only while DSR and CTS are both active.
// - After transmit transfer ends, DTR and RTS return inactive unless held.
// - Receive transfer raises only DTR; RTS stays inactive unless held.
// - Characters are accepted only while DSR and DCD are active.
// - Receive transfer end drops DTR unless its hold bit is set.
// - Modem bit 3 drives data-rate-select, bit 2 secondary RTS, directly.
// - Modem bit 1 holds RTS active, bit 0 holds DTR active.
// - Without hold bits, DTR toggles around each transfer and RTS around each transmit transfer.
// - Parity mismatch sets receive error bit 2.
// - A stop bit sampled low sets receive error bit 3; a bad start bit is dropped silently.
// - New character while previous unread sets receive error bit 1.
// - Break sets receive error bit 4 and framing bit 3.
// - Only received data sets error flags, never transmission.
// - Reading receive error status returns flags, then clears bits 1 to 4.
// - Receive path buffers exactly one character; a further one overruns.
// - Transmit done only after last stop bit has left the line.
// - Any error flag raises pending error until status is read.
module serial_port #(
	parameter int unsigned BIT_CYCLES = serial_pkg::BIT_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Serial line and modem pins
	input wire logic rxd_i,
	input wire logic dsr_i,
	input wire logic cts_i,
	input wire logic dcd_i,
	output logic txd_o,
	output logic dtr_o,
	output logic rts_o,
	output logic drs_o,
	output logic srts_o,
	// Host indications
	output logic err_pending_o,
	output logic irq_o
);
	typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_MARK} rx_state_t;

	localparam logic [15:0] BIT_LEN = 16'(BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LEN = 16'(BIT_CYCLES / 2);

	// Expected parity bit for a character under a given sense
	function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] sense);
		case (sense)
			serial_pkg::PAR_ODD: parity_bit = ~^data;
			serial_pkg::PAR_EVEN: parity_bit = ^data;
			serial_pkg::PAR_ONE: parity_bit = 1'b1;
			default: parity_bit = 1'b0;
		endcase
	endfunction

	// ******************************
	// Pin synchronisers
	// ******************************
	logic [3:0] sync1, sync2, sync3, pins;
	logic rxd, dsr, cts, dcd;
	// A pin change counts once the second and third stages agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 4'h1;
			sync2 <= 4'h1;
			sync3 <= 4'h1;
			pins <= 4'h1;
		end else begin
			sync1 <= {dcd_i, cts_i, dsr_i, rxd_i};
			sync2 <= sync1;
			sync3 <= sync2;
			for (int i = 0; i < 4; i++) begin
				if (sync2[i] == sync3[i]) begin
					pins[i] <= sync3[i];
				end
			end
		end
	end
	assign rxd = pins[0];
	assign dsr = pins[1];
	assign cts = pins[2];
	assign dcd = pins[3];

	// ******************************
	// Bus slave
	// ******************************
	logic [3:0] idx;
	logic req, wr, rd;
	logic [7:0] wdat, rdat;
	logic [1:0] ctrl;
	logic [7:0] modem, format;
	logic [4:0] rx_err;
	logic [2:0] irq_stat, irq_en;
	logic [7:0] rx_buf, tx_buf;
	logic rx_full, tx_pend, rx_seen;
	tx_state_t tx_state;
	assign idx = adr_i[5:2];
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = ack_o & cyc_i & stb_i & we_i & sel_i[0];
	assign rd = ack_o & cyc_i & stb_i & ~we_i;
	assign wdat = dat_i[7:0];

	// Read mux; unmapped and write-only indexes read zero
	always_comb begin
		rdat = 8'h00;
		case (idx)
			serial_pkg::IDX_CTRL: rdat = {6'h00, ctrl};
			serial_pkg::IDX_RXDATA: rdat = rx_buf;
			serial_pkg::IDX_LINESTAT: rdat = {2'h0, dcd, cts, dsr, rx_full, tx_pend, tx_state == TX_SHIFT};
			serial_pkg::IDX_FORMAT: rdat = format;
			serial_pkg::IDX_MODEM: rdat = modem;
			serial_pkg::IDX_IRQ_STAT: rdat = {5'h00, irq_stat};
			serial_pkg::IDX_IRQ_EN: rdat = {5'h00, irq_en};
			serial_pkg::IDX_RXERR: rdat = {3'h0, rx_err};
			default: rdat = 8'h00;
		endcase
	end

	// Ack one cycle after the request; read data captured with it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
			rx_seen <= 1'b0;
		end else begin
			ack_o <= req;
			if (req) begin
				dat_o <= {24'h00_0000, rdat};
				rx_seen <= rx_full;
			end
		end
	end

	// Writable configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= serial_pkg::CTRL_RST;
			modem <= serial_pkg::MODEM_RST;
			format <= serial_pkg::FORMAT_RST;
			irq_en <= 3'h0;
		end else if (wr) begin
			case (idx)
				serial_pkg::IDX_CTRL: ctrl <= wdat[1:0];
				serial_pkg::IDX_MODEM: modem <= wdat;
				serial_pkg::IDX_FORMAT: format <= wdat;
				serial_pkg::IDX_IRQ_EN: irq_en <= wdat[2:0];
				default: ;
			endcase
		end
	end

	// ******************************
	// Modem handshake lines
	// ******************************
	logic out_active, in_active, out_line, tx_permit;
	assign out_active = ctrl[serial_pkg::CTRL_OUT];
	assign in_active = ctrl[serial_pkg::CTRL_IN];
	// Lines stay up until the shifter empties so the last stop bit is covered
	assign out_line = out_active | tx_state == TX_SHIFT;
	assign tx_permit = out_active & dsr & cts;
	// Hold bits override the automatic toggling
	assign dtr_o = modem[serial_pkg::MLC_HOLD_DTR] | out_line | in_active;
	assign rts_o = modem[serial_pkg::MLC_HOLD_RTS] | out_line;
	assign drs_o = modem[serial_pkg::MLC_DRS];
	assign srts_o = modem[serial_pkg::MLC_SRTS];

	// ******************************
	// Transmitter
	// ******************************
	logic [9:0] tx_shift;
	logic [3:0] tx_bits;
	logic [15:0] tx_cnt;
	logic tx_load, tx_done;
	assign tx_load = tx_state == TX_IDLE && tx_pend && tx_permit;

	// One character holding register; writes while it is full are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_pend <= 1'b0;
			tx_buf <= 8'h00;
		end else if (wr && idx == serial_pkg::IDX_TXDATA && !tx_pend) begin
			tx_pend <= 1'b1;
			tx_buf <= wdat;
		end else if (tx_load) begin
			tx_pend <= 1'b0;
		end
	end

	// Start bit, data LSB first, optional parity, one stop bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state <= TX_IDLE;
			txd_o <= 1'b1;
			tx_shift <= 10'h3FF;
			tx_bits <= 4'h0;
			tx_cnt <= 16'h0000;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			case (tx_state)
				TX_IDLE: begin
					if (tx_load) begin
						txd_o <= 1'b0;
						tx_cnt <= BIT_LEN;
						tx_state <= TX_SHIFT;
						if (format[serial_pkg::FMT_PEN]) begin
							tx_shift <= {1'b1, parity_bit(tx_buf, format[5:4]), tx_buf};
							tx_bits <= 4'hA;
						end else begin
							tx_shift <= {2'h3, tx_buf};
							tx_bits <= 4'h9;
						end
					end
				end
				TX_SHIFT: begin
					if (tx_cnt != 16'h0000) begin
						tx_cnt <= tx_cnt - 16'h0001;
					end else if (tx_bits != 4'h0) begin
						txd_o <= tx_shift[0];
						tx_shift <= {1'b1, tx_shift[9:1]};
						tx_bits <= tx_bits - 4'h1;
						tx_cnt <= BIT_LEN;
					end else begin
						tx_state <= TX_IDLE;
						tx_done <= 1'b1;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// ******************************
	// Receiver
	// ******************************
	rx_state_t rx_state;
	logic [8:0] rx_shift;
	logic [3:0] rx_bits;
	logic [15:0] rx_cnt;
	logic rx_evt, rx_perr, rx_ferr, rx_brk, rx_accept;
	logic [7:0] rx_char, rx_data;
	logic rx_par, rx_zero;
	assign rx_data = format[serial_pkg::FMT_PEN] ? rx_shift[7:0] : rx_shift[8:1];
	assign rx_par = rx_shift[8];
	assign rx_zero = format[serial_pkg::FMT_PEN] ? rx_shift == 9'h000 : rx_shift[8:1] == 8'h00;

	// Samples at mid-bit; after a low stop bit waits for mark before hunting again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state <= RX_IDLE;
			rx_shift <= 9'h000;
			rx_bits <= 4'h0;
			rx_cnt <= 16'h0000;
			rx_evt <= 1'b0;
			rx_perr <= 1'b0;
			rx_ferr <= 1'b0;
			rx_brk <= 1'b0;
			rx_char <= 8'h00;
		end else begin
			rx_evt <= 1'b0;
			if (rx_cnt != 16'h0000) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end
			case (rx_state)
				RX_IDLE: begin
					if (!rxd) begin
						rx_cnt <= HALF_LEN;
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt == 16'h0000) begin
						rx_state <= rxd ? RX_IDLE : RX_BITS;
						rx_cnt <= BIT_LEN;
						rx_bits <= format[serial_pkg::FMT_PEN] ? 4'h9 : 4'h8;
					end
				end
				RX_BITS: begin
					if (rx_cnt == 16'h0000) begin
						rx_shift <= {rxd, rx_shift[8:1]};
						rx_bits <= rx_bits - 4'h1;
						rx_cnt <= BIT_LEN;
						if (rx_bits == 4'h1) begin
							rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_cnt == 16'h0000) begin
						rx_evt <= 1'b1;
						rx_char <= rx_data;
						rx_perr <= format[serial_pkg::FMT_PEN] && rx_par != parity_bit(rx_data, format[5:4]);
						rx_ferr <= !rxd;
						rx_brk <= !rxd && rx_zero;
						rx_state <= rxd ? RX_IDLE : RX_MARK;
					end
				end
				RX_MARK: begin
					if (rxd) begin
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Characters count only inside a receive transfer with DSR and DCD up
	assign rx_accept = rx_evt & in_active & dsr & dcd;

	// Single character buffer; an unread one is kept and the new one lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_full <= 1'b0;
			rx_buf <= 8'h00;
		end else begin
			if (rx_accept && !rx_full) begin
				rx_buf <= rx_char;
			end
			rx_full <= rx_accept | (rx_full & ~(rd && idx == serial_pkg::IDX_RXDATA && rx_seen));
		end
	end

	// ******************************
	// Error status and interrupts
	// ******************************
	logic [4:0] err_set, err_clr;
	logic [2:0] ev_set, ev_clr;
	// Only receiver events feed the error flags
	assign err_set = rx_accept ? {rx_brk, rx_ferr | rx_brk, rx_perr, rx_full, 1'b0} : 5'h00;
	// Only flags that the read returned are cleared, so a new one is kept
	assign err_clr = (rd && idx == serial_pkg::IDX_RXERR) ? dat_o[4:0] & 5'h1E : 5'h00;
	assign ev_set = {err_set != 5'h00, rx_accept, tx_done};
	assign ev_clr = (wr && idx == serial_pkg::IDX_IRQ_CLR) ? wdat[2:0] : 3'h0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_err <= 5'h00;
			irq_stat <= 3'h0;
		end else begin
			rx_err <= (rx_err & ~err_clr) | err_set;
			irq_stat <= (irq_stat & ~ev_clr) | ev_set;
		end
	end
	assign err_pending_o = rx_err != 5'h00;
	assign irq_o = (irq_stat & irq_en) != 3'h0;

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_tx_start_gate: assert property (tx_state == TX_IDLE ##1 tx_state == TX_SHIFT |-> $past(dsr && cts && out_active))
		else $error("Transmit started without DSR and CTS");
	a_out_lines_up: assert property ($rose(out_active) |-> dtr_o && rts_o)
		else $error("DTR or RTS not active at transmit start");
	a_out_lines_drop: assert property (!modem[1] && !modem[0] && !in_active && !out_line |-> !rts_o && !dtr_o)
		else $error("Handshake lines left active after transfer");
	a_rx_dtr_only: assert property (in_active && !out_line && !modem[1] |-> dtr_o && !rts_o)
		else $error("Receive transfer handshake wrong");
	a_rx_gate: assert property ($rose(rx_full) |-> $past(in_active && dsr && dcd))
		else $error("Character accepted without DSR and DCD");
	a_modem_direct: assert property (wr && idx == serial_pkg::IDX_MODEM |=> drs_o == $past(wdat[3]) && srts_o == $past(wdat[2]))
		else $error("DRS or SRTS does not follow modem register");
	a_hold_lines: assert property (wr && idx == serial_pkg::IDX_MODEM && wdat[1:0] == 2'h3 |=> (rts_o && dtr_o) [*2])
		else $error("Held lines not active");
	a_parity_flag: assert property (rx_accept && rx_perr |=> rx_err[2])
		else $error("Parity error not recorded");
	a_framing_flag: assert property (rx_accept && rx_ferr |=> rx_err[3])
		else $error("Framing error not recorded");
	a_overrun_flag: assert property (rx_accept && rx_full |=> rx_err[1] && rx_buf == $past(rx_buf))
		else $error("Overrun not recorded or buffer overwritten");
	a_break_framing: assert property (rx_err[4] |-> rx_err[3])
		else $error("Break without framing flag");
	a_err_only_rx: assert property ((rx_err & ~$past(rx_err)) != 5'h00 |-> $past(rx_accept))
		else $error("Error flag set without received character");
	a_err_read_clear: assert property (err_clr != 5'h00 && !rx_accept |=> (rx_err & $past(err_clr)) == 5'h00)
		else $error("Read did not clear error flags");
	a_done_after_stop: assert property (tx_done |-> $past(txd_o) && $past(tx_cnt) == 16'h0000 && $past(tx_bits) == 4'h0)
		else $error("Transmit done before stop bit finished");
	a_pending_err: assert property ($rose(rx_err != 5'h00) |-> err_pending_o ##1 (err_pending_o || $past(rd)))
		else $error("Pending error not raised or dropped early");

	c_tx_char: cover property (tx_state == TX_SHIFT ##1 tx_done);
	c_rx_break: cover property (rx_accept && rx_brk);
	c_rx_overrun: cover property (rx_accept && rx_full);
	c_err_read: cover property (err_clr != 5'h00);
endmodule
`default_nettype wire

// File: tb/modem_peer.sv
// Far-side modem model: drives receive and status lines, decodes transmitted characters
`default_nettype none
module modem_peer #(
	parameter int BC = 16
) (
	// Clock and transmit line from the port
	input wire logic clk_i,
	input wire logic txd_i,
	// Lines towards the port
	output var logic rxd_o,
	output var logic dsr_o,
	output var logic cts_o,
	output var logic dcd_o,
	// Decoded character, one-cycle strobe
	output var logic got_o,
	output var logic [7:0] char_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Line driver and frame decoder
	// ****************************************
	// Status lines start inactive so the port must wait for the bench
	initial begin
		rxd_o = 1'b1;
		dsr_o = 1'b0;
		cts_o = 1'b0;
		dcd_o = 1'b0;
		got_o = 1'b0;
		char_o = 8'h00;
	end
	// Status lines take whatever levels the bench passes, including mixes that hold a transfer off
	task automatic lines(input logic dsr, input logic cts, input logic dcd);
		dsr_o <= dsr;
		cts_o <= cts;
		dcd_o <= dcd;
	endtask
	// One frame LSB first; parity and stop level chosen by the caller to inject faults
	task automatic send(input logic [7:0] c, input logic pen, input logic par, input logic stp);
		rxd_o <= 1'b0;
		repeat (BC) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			rxd_o <= c[i];
			repeat (BC) @(posedge clk_i);
		end
		if (pen) begin
			rxd_o <= par;
			repeat (BC) @(posedge clk_i);
		end
		rxd_o <= stp;
		repeat (BC) @(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (3 * BC) @(posedge clk_i);
	endtask
	// Mid-bit sampling; a low stop bit gives no strobe, so the bench sees a lost character
	initial begin
		forever begin
			@(negedge txd_i);
			repeat (BC / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BC) @(posedge clk_i);
				char_o[i] <= txd_i;
			end
			repeat (BC) @(posedge clk_i);
			got_o <= txd_i;
			@(posedge clk_i);
			got_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: tb/tb_serial_port.sv
// Self-checking bench for the serial port: registers, modem handshake, transmit, receive errors
`default_nettype none
module tb_serial_port;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Signals, instances and checkers
	// ****************************************
	localparam int BC = 16;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [5:0] adr_i = 6'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o, txd_o, dtr_o, rts_o, drs_o, srts_o, err_pending_o, irq_o;
	logic rxd, dsr, cts, dcd, got;
	logic [7:0] tx_char, a, b;
	logic [32:0] e;
	logic [32:0] rd_q[$];
	logic [7:0] tx_q[$];
	logic [7:0] errs[6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h00, 8'h00};
	// Odd, then even three times, then always one, then always zero, all with parity enabled
	logic [7:0] fmts[6] = '{8'h08, 8'h18, 8'h18, 8'h18, 8'h28, 8'h38};
	int failures = 0;
	int cmp_count = 0;
	int tx_seen = 0;
	serial_port #(.BIT_CYCLES(BC)) u_serial_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd),
		.dsr_i(dsr), .cts_i(cts), .dcd_i(dcd), .txd_o(txd_o), .dtr_o(dtr_o), .rts_o(rts_o), .drs_o(drs_o),
		.srts_o(srts_o), .err_pending_o(err_pending_o), .irq_o(irq_o));
	modem_peer #(.BC(BC)) u_modem_peer (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd), .dsr_o(dsr), .cts_o(cts),
		.dcd_o(dcd), .got_o(got), .char_o(tx_char));
	// 100 MHz clock
	initial begin
		forever begin
			#5 clk_i = ~clk_i;
		end
	end
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Classic single cycle; request held until ack is sampled, then one idle cycle
	task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h00_0000, d};
		@(posedge clk_i);
		for (int n = 0; n < 64 && ack_o !== 1'b1; n++) @(posedge clk_i);
		// A missing answer is a mismatch, not a silent pass
		if (ack_o !== 1'b1) failures++;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
		rd_q.push_back({1'b0, 24'h00_0000, exp});
		bus(1'b0, idx, 8'h00);
	endtask
	// Read whose value is of no interest, only its side effect
	task automatic skip(input logic [3:0] idx);
		rd_q.push_back({1'b1, 32'h0000_0000});
		bus(1'b0, idx, 8'h00);
	endtask
	task automatic hs(input logic [3:0] exp);
		cmp("dtr rts drs srts", {28'h000_0000, exp}, {28'h000_0000, dtr_o, rts_o, drs_o, srts_o});
	endtask
	task automatic tally_and_finish();
		$display("Compares %0d, failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Each read answer is matched against the oldest note of the driver
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0) begin
			e = rd_q.pop_front();
			if (!e[32]) cmp("read data", e[31:0], dat_o);
		end
	end
	// Each character seen on the transmit line is matched in order
	always @(posedge clk_i) begin
		if (got === 1'b1) begin
			tx_seen++;
			cmp("tx char", {24'h00_0000, tx_q.pop_front()}, {24'h00_0000, tx_char});
		end
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clk_i);
		failures++;
		tally_and_finish();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		void'($urandom(32'h535b_fb01));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset state, defaults and an unmapped place
		hs(4'h0);
		cmp("txd err irq", 32'h0000_0004, {29'h0, txd_o, err_pending_o, irq_o});
		rd(serial_pkg::IDX_MODEM, serial_pkg::MODEM_RST);
		rd(serial_pkg::IDX_RXERR, 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		// Direct and hold bits of the modem register
		wr(serial_pkg::IDX_MODEM, 8'h0C);
		hs(4'h3);
		wr(serial_pkg::IDX_MODEM, 8'h03);
		hs(4'hC);
		wr(serial_pkg::IDX_MODEM, 8'h00);
		hs(4'h0);
		// Outbound transfer held off while one permit line is missing
		a = 8'($urandom());
		tx_q.push_back(a);
		wr(serial_pkg::IDX_IRQ_EN, 8'h01);
		wr(serial_pkg::IDX_TXDATA, a);
		wr(serial_pkg::IDX_CTRL, 8'h01);
		hs(4'hC);
		u_modem_peer.lines(1'b1, 1'b0, 1'b1);
		repeat (40) @(posedge clk_i);
		rd(serial_pkg::IDX_LINESTAT, 8'h2A);
		u_modem_peer.lines(1'b1, 1'b1, 1'b1);
		for (int n = 0; n < 4000 && irq_o !== 1'b1; n++) @(posedge clk_i);
		cmp("frames before done", 32'h1, tx_seen);
		cmp("irq", 32'h1, {31'h0000_0000, irq_o});
		wr(serial_pkg::IDX_IRQ_EN, 8'h00);
		cmp("irq masked", 32'h0, {31'h0000_0000, irq_o});
		rd(serial_pkg::IDX_IRQ_STAT, 8'h01);
		wr(serial_pkg::IDX_IRQ_EN, 8'h01);
		wr(serial_pkg::IDX_IRQ_CLR, 8'h01);
		cmp("irq cleared", 32'h0, {31'h0000_0000, irq_o});
		wr(serial_pkg::IDX_CTRL, 8'h00);
		hs(4'h0);
		rd(serial_pkg::IDX_RXERR, 8'h00);
		// Inbound transfer raises only DTR; carrier alone does not admit data
		u_modem_peer.lines(1'b0, 1'b1, 1'b1);
		wr(serial_pkg::IDX_CTRL, 8'h02);
		hs(4'h8);
		wr(serial_pkg::IDX_MODEM, 8'h02);
		hs(4'hC);
		wr(serial_pkg::IDX_MODEM, 8'h00);
		u_modem_peer.send(8'h5A, 1'b0, 1'b0, 1'b1);
		rd(serial_pkg::IDX_LINESTAT, 8'h30);
		// Two characters unread: the first is kept, overrun flagged
		u_modem_peer.lines(1'b1, 1'b0, 1'b1);
		a = 8'($urandom());
		b = 8'($urandom());
		u_modem_peer.send(a, 1'b0, 1'b0, 1'b1);
		rd(serial_pkg::IDX_LINESTAT, 8'h2C);
		u_modem_peer.send(b, 1'b0, 1'b0, 1'b1);
		cmp("pending", 32'h1, {31'h0000_0000, err_pending_o});
		rd(serial_pkg::IDX_RXERR, 8'h02);
		rd(serial_pkg::IDX_RXERR, 8'h00);
		rd(serial_pkg::IDX_RXDATA, a);
		cmp("pending", 32'h0, {31'h0000_0000, err_pending_o});
		// Odd clean, even parity fault, framing fault, break, then clean with parity one and zero
		for (int k = 0; k < 6; k++) begin
			wr(serial_pkg::IDX_FORMAT, fmts[k]);
			a = (k == 3) ? 8'h00 : (8'($urandom()) | 8'h01);
			u_modem_peer.send(a, 1'b1, (k == 4) ? 1'b1 : (k == 5) ? 1'b0 : (^a) ^ (k < 2), k < 2 || k > 3);
			if (k > 0 && k < 4) cmp("pending", 32'h1, {31'h0000_0000, err_pending_o});
			else cmp("no pending", 32'h0, {31'h0000_0000, err_pending_o});
			rd(serial_pkg::IDX_RXERR, errs[k]);
			if (k == 0 || k > 3) rd(serial_pkg::IDX_RXDATA, a);
			else skip(serial_pkg::IDX_RXDATA);
		end
		wr(serial_pkg::IDX_CTRL, 8'h00);
		hs(4'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
